/* File: rtl/inertial_output_bias_defs.svh */
/*
 Register byte addresses, reset values and timing figures for the
 velocity change outputs and gyro rate offset registers.
 Assumes inclusion by bare name from the design files.
*/
`ifndef INERTIAL_OUTPUT_BIAS_DEFS_SVH
`define INERTIAL_OUTPUT_BIAS_DEFS_SVH

`define ADDR_Y_VEL_LOW 8'h34
`define ADDR_Y_VEL_HIGH 8'h36
`define ADDR_Z_VEL_LOW 8'h38
`define ADDR_Z_VEL_HIGH 8'h3a
`define ADDR_X_RATE_OFS_LOW 8'h40
`define ADDR_X_RATE_OFS_HIGH 8'h42
`define ADDR_Y_RATE_OFS_LOW 8'h44
`define ADDR_Y_RATE_OFS_HIGH 8'h46

`define RATE_OFS_RESET 16'h0000
`define VEL_RESET 16'h0000
`define READ_IDLE 16'h0000

`define CORE_CLK_HZ 50000000
`define SAMPLE_RATE_HZ 2000
`define SAMPLE_DIV_CYCLES (`CORE_CLK_HZ / `SAMPLE_RATE_HZ)

`define POS_FULL_SCALE 32'h7fff_ffff
`define NEG_FULL_SCALE 32'h8000_0000

`endif

/* File: rtl/inertial_output_bias_pkg.sv */
/*
 Types shared by the register bank: a 32-bit value split into its
 upper and low register words.
 Assumes nothing of its surroundings.
*/
package inertial_output_bias_pkg;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } word_pair_t;

    typedef struct packed {
        word_pair_t x;
        word_pair_t y;
    } rate_pair_t;

endpackage

/* File: rtl/inertial_output_bias_regs.sv */
/*
 Register bank for y/z velocity change outputs and x/y gyro rate offsets,
 plus the sample-rate offset adder on the x/y gyro rate path.
 Assumes the integrator and factory correction logic sit on core_clk and
 present their values as plain same-clock inputs; the flash keeper
 reloads the offsets through the restore port after power-up.
*/
`timescale 1ns/1ns

`include "inertial_output_bias_defs.svh"

module inertial_output_bias_regs
    import inertial_output_bias_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = `SAMPLE_DIV_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire word_pair_t y_vel_in,
    input wire word_pair_t z_vel_in,
    input wire rate_pair_t rate_in,
    output rate_pair_t rate_out,
    output logic sample_tick,
    output rate_pair_t ofs_image,
    input wire logic restore_valid,
    input wire rate_pair_t restore_ofs
);

    logic [15:0] div_reg;
    logic [15:0] div_next;
    word_pair_t y_vel_reg;
    word_pair_t y_vel_next;
    word_pair_t z_vel_reg;
    word_pair_t z_vel_next;
    rate_pair_t ofs_reg;
    rate_pair_t ofs_next;
    rate_pair_t rate_reg;
    rate_pair_t rate_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [7:0] word_addr;

    // offsets aligned to a 16-bit word; bit 0 is ignored, so either byte address reaches the whole word
    assign word_addr = {reg_addr[7:1], 1'b0};

    // signed add that clamps at full scale instead of wrapping
    function automatic word_pair_t sat_add(input word_pair_t a, input word_pair_t b);
        logic [32:0] sum;
        word_pair_t res;
        sum = {a[31], a} + {b[31], b};
        if (sum[32] != sum[31]) begin
            res = sum[32] ? `NEG_FULL_SCALE : `POS_FULL_SCALE;
        end else begin
            res = sum[31:0];
        end
        return res;
    endfunction

    // sample rate divider
    always_comb begin
        if (div_reg == 16'(SAMPLE_DIV - 1)) begin
            div_next = 16'h0000;
        end else begin
            div_next = div_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_next;
        end
    end

    assign sample_tick = (div_reg == 16'(SAMPLE_DIV - 1));

    // velocity change capture; the pair is taken whole so both words agree
    always_comb begin
        y_vel_next = y_vel_reg;
        z_vel_next = z_vel_reg;
        if (sample_tick) begin
            y_vel_next = y_vel_in;
            z_vel_next = z_vel_in;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            y_vel_reg <= {`VEL_RESET, `VEL_RESET};
            z_vel_reg <= {`VEL_RESET, `VEL_RESET};
        end else begin
            y_vel_reg <= y_vel_next;
            z_vel_reg <= z_vel_next;
        end
    end

    // rate offsets; a host write wins over a flash restore in the same cycle
    always_comb begin
        ofs_next = ofs_reg;
        if (restore_valid) begin
            ofs_next = restore_ofs;
        end
        if (reg_wr) begin
            case (word_addr)
                `ADDR_X_RATE_OFS_LOW: begin
                    ofs_next.x.low = reg_wdata;
                end
                `ADDR_X_RATE_OFS_HIGH: begin
                    ofs_next.x.high = reg_wdata;
                end
                `ADDR_Y_RATE_OFS_LOW: begin
                    ofs_next.y.low = reg_wdata;
                end
                `ADDR_Y_RATE_OFS_HIGH: begin
                    ofs_next.y.high = reg_wdata;
                end
                default: begin
                    ofs_next = ofs_next;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_reg <= {4{`RATE_OFS_RESET}};
        end else begin
            ofs_reg <= ofs_next;
        end
    end

    assign ofs_image = ofs_reg;

    // offset adder: one result per sample, so a half-written pair can
    // affect at most the samples taken between the two word writes
    word_pair_t sum_axes [2];

    // one saturating adder per axis; index 1 is x and 0 is y, as packed
    for (genvar axis = 0; axis < 2; axis++) begin : g_axis_add
        assign sum_axes[axis] = sat_add(rate_in[axis*32 +: 32], ofs_reg[axis*32 +: 32]);
    end

    always_comb begin
        rate_next = rate_reg;
        if (sample_tick) begin
            rate_next.x = sum_axes[1];
            rate_next.y = sum_axes[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_reg <= {4{`VEL_RESET}};
        end else begin
            rate_reg <= rate_next;
        end
    end

    assign rate_out = rate_reg;

    // read port; factory terms have no address at all
    always_comb begin
        rdata_next = `READ_IDLE;
        if (reg_rd) begin
            case (word_addr)
                `ADDR_Y_VEL_LOW: begin
                    rdata_next = y_vel_reg.low;
                end
                `ADDR_Y_VEL_HIGH: begin
                    rdata_next = y_vel_reg.high;
                end
                `ADDR_Z_VEL_LOW: begin
                    rdata_next = z_vel_reg.low;
                end
                `ADDR_Z_VEL_HIGH: begin
                    rdata_next = z_vel_reg.high;
                end
                `ADDR_X_RATE_OFS_LOW: begin
                    rdata_next = ofs_reg.x.low;
                end
                `ADDR_X_RATE_OFS_HIGH: begin
                    rdata_next = ofs_reg.x.high;
                end
                `ADDR_Y_RATE_OFS_LOW: begin
                    rdata_next = ofs_reg.y.low;
                end
                `ADDR_Y_RATE_OFS_HIGH: begin
                    rdata_next = ofs_reg.y.high;
                end
                default: begin
                    rdata_next = `READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= `READ_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // helper for the assertions: cycles since the last sample tick
    logic [15:0] gap_reg;
    logic [15:0] gap_next;
    logic seen_reg;
    logic seen_next;

    always_comb begin
        gap_next = gap_reg + 16'h0001;
        if (sample_tick) begin
            gap_next = 16'h0000;
        end
        seen_next = seen_reg | sample_tick;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 16'h0000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            seen_reg <= seen_next;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!rst_n);

    tick_spacing_a: assert property (
        (sample_tick && seen_reg) |-> gap_reg == 16'(SAMPLE_DIV - 1)
    ) else $error("sample tick spacing wrong");

    tick_single_a: assert property (
        sample_tick |=> (!sample_tick)[*8]
    ) else $error("sample tick not a single pulse");

    y_low_read_a: assert property (
        (reg_rd && word_addr == `ADDR_Y_VEL_LOW) |=> reg_rdata == $past(y_vel_reg.low)
    ) else $error("y velocity low word read wrong");

    vel_readonly_a: assert property (
        (reg_wr && !sample_tick) |=> ($stable(y_vel_reg) && $stable(z_vel_reg))
    ) else $error("velocity word changed by a write");

    z_pair_capture_a: assert property (
        sample_tick |=> z_vel_reg == $past(z_vel_in)
    ) else $error("z velocity pair not captured whole");

    vel_zero_a: assert property (
        (reg_rd && word_addr == `ADDR_Y_VEL_HIGH && y_vel_reg == 32'h0000_0000)
        |=> reg_rdata == 16'h0000
    ) else $error("zero velocity not read as zero");

    x_ofs_write_a: assert property (
        (reg_wr && word_addr == `ADDR_X_RATE_OFS_HIGH) ##1 (!reg_wr && !restore_valid) ##1
        (reg_rd && word_addr == `ADDR_X_RATE_OFS_HIGH) |=> reg_rdata == $past(reg_wdata, 3)
    ) else $error("x offset upper word not stored");

    y_ofs_write_a: assert property (
        (reg_wr && word_addr == `ADDR_Y_RATE_OFS_LOW) |=> ofs_reg.y.low == $past(reg_wdata)
    ) else $error("y offset lower word not stored");

    zero_ofs_pass_a: assert property (
        (sample_tick && ofs_reg.x == 32'h0000_0000) |=> rate_out.x == $past(rate_in.x)
    ) else $error("zero offset changed the x rate");

    high_ofs_scale_a: assert property (
        (sample_tick && ofs_reg.y == 32'h0001_0000 && rate_in.y == 32'h0000_0000)
        |=> rate_out.y == 32'h0001_0000
    ) else $error("upper offset word scaling wrong");

    unmapped_read_a: assert property (
        (reg_rd && word_addr == 8'h30) |=> reg_rdata == `READ_IDLE
    ) else $error("unmapped address read nonzero");

    idle_rdata_a: assert property (
        !reg_rd |=> reg_rdata == `READ_IDLE
    ) else $error("read data outside read answer");

    y_high_read_a: assert property (
        (reg_rd && word_addr == `ADDR_Y_VEL_HIGH) |=> reg_rdata == $past(y_vel_reg.high)
    ) else $error("y velocity upper word read wrong");

    z_low_read_a: assert property (
        (reg_rd && word_addr == `ADDR_Z_VEL_LOW) |=> reg_rdata == $past(z_vel_reg.low)
    ) else $error("z velocity low word read wrong");

    z_high_read_a: assert property (
        (reg_rd && word_addr == `ADDR_Z_VEL_HIGH) |=> reg_rdata == $past(z_vel_reg.high)
    ) else $error("z velocity upper word read wrong");

    y_pair_capture_a: assert property (
        sample_tick |=> y_vel_reg == $past(y_vel_in)
    ) else $error("y velocity pair not captured whole");

    x_low_write_a: assert property (
        (reg_wr && word_addr == `ADDR_X_RATE_OFS_LOW) |=> ofs_reg.x.low == $past(reg_wdata)
    ) else $error("x offset lower word not stored");

    y_high_write_a: assert property (
        (reg_wr && word_addr == `ADDR_Y_RATE_OFS_HIGH) |=> ofs_reg.y.high == $past(reg_wdata)
    ) else $error("y offset upper word not stored");

    x_low_read_a: assert property (
        (reg_rd && word_addr == `ADDR_X_RATE_OFS_LOW) |=> reg_rdata == $past(ofs_reg.x.low)
    ) else $error("x offset lower word read wrong");

    restore_load_a: assert property (
        (restore_valid && !reg_wr) |=> ofs_image == $past(restore_ofs)
    ) else $error("flash restore not loaded");

    rate_hold_a: assert property (
        !sample_tick |=> $stable(rate_out)
    ) else $error("rate output changed between samples");

    rate_no_wrap_a: assert property (
        (sample_tick && !rate_in.y[31] && !ofs_reg.y[31]) |=> !rate_out.y[31]
    ) else $error("positive rate sum wrapped negative");

endmodule // inertial_output_bias_regs

/* File: dv/host_model.sv */
/*
 Host side of the register bus: one-cycle write and read strobes.
 Assumes each task is entered right after a rising core_clk edge.
*/
`timescale 1ns/1ns
module host_model (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // spare edge: a following write never re-drives reg_wr in one step
        @(posedge core_clk);
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
endmodule // host_model

/* File: dv/inertial_output_bias_regs_tb.sv */
/*
 Self-checking bench for the velocity and rate offset register bank.
 Assumes a short sample divider of 16 core_clk cycles.
*/
`timescale 1ns/1ns
module inertial_output_bias_regs_tb import inertial_output_bias_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    word_pair_t y_vel_in = 32'h0000_0000;
    word_pair_t z_vel_in = 32'h0000_0000;
    rate_pair_t rate_in = 64'h0000_0000_0000_0000;
    rate_pair_t rate_out;
    rate_pair_t ofs_image;
    rate_pair_t restore_ofs = 64'h0000_0000_0000_0000;
    logic sample_tick;
    logic restore_valid = 1'b0;
    int err_count = 0;
    int check_count = 0;
    logic [15:0] h;
    logic [15:0] l;
    int n;

    always #10 core_clk = ~core_clk;

    host_model host_model_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    inertial_output_bias_regs #(.SAMPLE_DIV(16)) inertial_output_bias_regs_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .y_vel_in(y_vel_in),
        .z_vel_in(z_vel_in), .rate_in(rate_in), .rate_out(rate_out),
        .sample_tick(sample_tick), .ofs_image(ofs_image), .restore_valid(restore_valid),
        .restore_ofs(restore_ofs));

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // leaves the bench just after the tick edge, at the following falling edge
    task automatic wait_tick();
        for (n = 0; n < 40 && sample_tick !== 1'b1; n++) @(negedge core_clk);
        chk("tick seen", sample_tick, 1'b1);
        @(negedge core_clk);
    endtask

    task automatic t_reset();
        @(posedge core_clk);
        host_model_i.rd(8'h40, l);
        host_model_i.rd(8'h42, h);
        chk("x offset reset", {h, l}, 32'h0000_0000);
        host_model_i.rd(8'h44, l);
        host_model_i.rd(8'h46, h);
        chk("y offset reset", {h, l}, 32'h0000_0000);
        host_model_i.rd(8'h36, h);
        chk("zero velocity", h, 16'h0000);
    endtask

    task automatic t_offsets();
        host_model_i.wr(8'h40, 16'h0100);
        host_model_i.wr(8'h45, 16'hff00);
        host_model_i.wr(8'h46, 16'hffff);
        host_model_i.wr(8'h43, 16'h0000);
        host_model_i.rd(8'h42, h);
        host_model_i.rd(8'h41, l);
        chk("x offset", {h, l}, 32'h0000_0100);
        host_model_i.rd(8'h44, l);
        host_model_i.rd(8'h47, h);
        chk("y offset", {h, l}, 32'hffff_ff00);
        chk("offset image", ofs_image, 64'h0000_0100_ffff_ff00);
        host_model_i.rd(8'h60, l);
        chk("unmapped read", l, 16'h0000);
        host_model_i.rd(8'h31, l);
        chk("unmapped read low", l, 16'h0000);
    endtask

    task automatic t_velocity();
        y_vel_in <= 32'h7fff_ffff;
        z_vel_in <= 32'h8000_0000;
        @(negedge core_clk);
        wait_tick();
        @(posedge core_clk);
        host_model_i.wr(8'h36, 16'h1234);
        host_model_i.rd(8'h34, l);
        host_model_i.rd(8'h37, h);
        chk("y velocity", {h, l}, 32'h7fff_ffff);
        host_model_i.rd(8'h38, l);
        host_model_i.rd(8'h3a, h);
        chk("z velocity", {h, l}, 32'h8000_0000);
    endtask

    // offsets x=+256, y=-256 from the t_offsets scenario
    task automatic t_rate();
        rate_in <= 64'h7fff_fff0_0000_1000;
        @(negedge core_clk);
        wait_tick();
        chk("rate clamp high", rate_out, 64'h7fff_ffff_0000_0f00);
        for (n = 1; n < 40 && sample_tick !== 1'b1; n++) @(negedge core_clk);
        chk("tick spacing", n, 16);
        // driven just after this tick edge, so the next tick takes it
        @(posedge core_clk);
        rate_in.y <= 32'h8000_0000;
        @(negedge core_clk);
        wait_tick();
        chk("rate clamp low", rate_out.y, 32'h8000_0000);
    endtask

    task automatic t_restore();
        @(posedge core_clk);
        restore_ofs <= 64'h1234_5678_9abc_def0;
        restore_valid <= 1'b1;
        @(posedge core_clk);
        restore_valid <= 1'b0;
        host_model_i.rd(8'h42, h);
        chk("restored offset", h, 16'h1234);
        chk("restored image", ofs_image, 64'h1234_5678_9abc_def0);
        host_model_i.wr(8'h44, 16'h0000);
        host_model_i.wr(8'h46, 16'h0001);
        rate_in <= 64'h0000_0000_0000_0000;
        @(negedge core_clk);
        wait_tick();
        chk("upper offset scale", rate_out, 64'h1234_5678_0001_0000);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_offsets();
        t_velocity();
        t_rate();
        t_restore();
        print_verdict();
    end

    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
endmodule // inertial_output_bias_regs_tb
